// ===== adcrc_regs.vh
// register layout, field positions and timing counts of the converter control block
`ifndef ADCRC_REGS_VH
`define ADCRC_REGS_VH

// write word address codes, bits 15:14
`define ADCRC_ADDR_MSB        15
`define ADCRC_ADDR_LSB        14
`define ADCRC_ADDR_NONE       2'h0
`define ADCRC_ADDR_CONTROL    2'h3

// control register fields
`define ADCRC_CTRL_WIDTH      14
`define ADCRC_CTRL_RESET      14'h0000
`define ADCRC_CTRL_KEEP_MASK  14'h3ff0
`define ADCRC_BIT_START       4
`define ADCRC_BIT_ANALOG_MODE_BIT       5
`define ADCRC_RDSEL_LSB       6
`define ADCRC_RDSEL_MSB       7
`define ADCRC_PMGT_LSB        8
`define ADCRC_PMGT_MSB        9
`define ADCRC_CHSEL_LSB       10
`define ADCRC_CHSEL_MSB       12
`define ADCRC_BIT_INMODE      13

// read select codes
`define ADCRC_RDSEL_RESULT    2'h0
`define ADCRC_RDSEL_STATUS    2'h3

// status register
`define ADCRC_STATUS_RESET    16'h0000
`define ADCRC_STAT_BUSY       4

// negative input codes
`define ADCRC_NEG_GROUND      2'h0
`define ADCRC_NEG_INPUT8      2'h1
`define ADCRC_NEG_PAIR        2'h2

// power modes
`define ADCRC_PWR_FULL_UP     2'h0
`define ADCRC_PWR_DOWN_BETW   2'h1
`define ADCRC_PWR_FULL_DOWN   2'h2
`define ADCRC_PWR_PART_BETW   2'h3

// timing
`define ADCRC_CLK_PERIOD_NS   10
`define ADCRC_SETUP_NS        10
`define ADCRC_SETUP_CYC       ((`ADCRC_SETUP_NS + `ADCRC_CLK_PERIOD_NS - 1) / `ADCRC_CLK_PERIOD_NS)
// 16.5 master clock periods expressed as half periods
`define ADCRC_CONV_HALF_PER   33

`endif

// ===== adcrc_sync.v
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module adcrc_sync #(
  parameter             WIDTH     = 1,
  // per-bit level held through reset, so each output starts at its pin's idle level
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             reset_n_in,
  // asynchronous inputs and synchronised outputs
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ===== adcrc_top.v
// conversion timing, register write decode and read select of the converter control block
`timescale 1ns/10ps
`include "adcrc_regs.vh"

//Function
//- rising start pin switches track/hold to hold and requests a conversion
//- hardware conversion begins on first master falling edge at least 10ns later
//- writing control register with start bit one enters hold at write end
//- software conversion begins on master falling edge at least 10ns after strobe rise
//- conversion lasts 16.5 master periods, or 17.5 when setup was missed
//- completion drops busy and latches the result for bus reads
//- busy falling edge clears the software start bit
//- word mode writes all 16 bits at once on data lines
//- byte mode writes low byte then high byte, high-byte enable picks which
//- top two bits of the write word are address, lower 14 are data
//- address 11 selects control register, 00 selects none, address bits not stored
//- read select powers up 00 selecting result, holds until rewritten
//- read select 11 makes reads return the status register
//- result reads show four zero bits above the 12-bit result
//- control register is write-only, 14 bits, all zero at power-up
//- differential mode: analog mode bit picks unipolar or bipolar range
//- single-ended mode: analog mode bit picks ground or input 8 as negative
//- differential codes 000-011 pick pairs 1/2 to 7/8, top bit set unused
//- single-ended codes pick inputs 1,3,5,7,2,4,6,8 in order
//- input mode bit 13 selects differential when 0, single-ended when 1
//- power bits with sleep pin select the power-down mode
//- status register is read-only, 16 bits, all zero at power-up
//- busy rises at initiation and stays high until completion
//- status bit 4 mirrors busy, zero when idle
//- results are straight binary unipolar, two's complement bipolar
module adcrc_top (
  // clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  // conversion pins
  input  wire        start_pin_in,
  input  wire        master_clock_in,
  input  wire        sleep_pin_n_in,
  // parallel bus
  input  wire        chip_select_n_in,
  input  wire        write_strobe_n_in,
  input  wire        read_strobe_n_in,
  input  wire        width_select_pin_in,
  input  wire [15:0] data_lines_in,
  output reg  [15:0] data_lines_out,
  output reg         data_lines_oe_n_out,
  // raw offset-binary code from the analog core
  input  wire [11:0] conv_code_in,
  // conversion status
  output reg         busy_out,
  output reg         hold_out,
  // analog front-end control
  output reg  [2:0]  pos_input_out,
  output reg  [1:0]  neg_input_out,
  output reg         channel_unused_out,
  output reg         bipolar_out,
  output reg  [1:0]  power_mode_out,
  output reg         power_down_out
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_ARMED = 2'h1;
  localparam ST_CONV  = 2'h2;

  localparam integer SETUP_I   = `ADCRC_SETUP_CYC;
  localparam integer CONV_I    = `ADCRC_CONV_HALF_PER;
  localparam [3:0]   SETUP_CYC = SETUP_I[3:0];
  localparam [5:0]   CONV_HALF = CONV_I[5:0];

  // pin synchronisers
  wire [6:0]  pins_s;
  wire [15:0] data_s;

  // active-low pins leave reset high, else a false write edge and bus drive follow reset
  adcrc_sync #(.WIDTH(7), .RESET_VAL(7'h1e)) u_pin_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({start_pin_in, master_clock_in, sleep_pin_n_in, chip_select_n_in,
                  write_strobe_n_in, read_strobe_n_in, width_select_pin_in}),
    .sync_out   (pins_s)
  );

  adcrc_sync #(.WIDTH(16)) u_data_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (data_lines_in),
    .sync_out   (data_s)
  );

  wire start_s = pins_s[6];
  wire mclk_s  = pins_s[5];
  wire sleep_n = pins_s[4];
  wire cs_n    = pins_s[3];
  wire wr_n    = pins_s[2];
  wire rd_n    = pins_s[1];
  wire word_md = pins_s[0];

  // straight binary for unipolar, two's complement for bipolar
  function [11:0] adcrc_code;
    input [11:0] raw;
    input        bip;
    begin
      adcrc_code = bip ? {~raw[11], raw[10:0]} : raw;
    end
  endfunction

  // read mux; unmapped read select codes return zero
  function [15:0] adcrc_read_word;
    input [1:0]  sel;
    input [11:0] result;
    input [15:0] status;
    begin
      case (sel)
        `ADCRC_RDSEL_RESULT: adcrc_read_word = {4'h0, result};
        `ADCRC_RDSEL_STATUS: adcrc_read_word = status;
        default:             adcrc_read_word = 16'h0000;
      endcase
    end
  endfunction

  // edge history of synchronised pins
  reg        start_prev_q;
  reg        mclk_prev_q;
  reg        wr_prev_q;
  reg        cs_prev_q;
  reg [15:0] data_prev_q;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_prev_q <= 1'b0;
      mclk_prev_q  <= 1'b0;
      wr_prev_q    <= 1'b1;
      cs_prev_q    <= 1'b1;
      data_prev_q  <= 16'h0000;
    end else begin
      start_prev_q <= start_s;
      mclk_prev_q  <= mclk_s;
      wr_prev_q    <= wr_n;
      cs_prev_q    <= cs_n;
      data_prev_q  <= data_s;
    end
  end

  wire mclk_fall = mclk_prev_q & ~mclk_s;
  wire mclk_edge = mclk_prev_q ^ mclk_s;
  wire hw_start  = start_s & ~start_prev_q;
  // data sampled as it stood just before the strobe rose
  wire wr_done   = wr_n & ~wr_prev_q & ~cs_prev_q;

  // write word assembly
  reg [7:0]  low_byte_q;
  reg        low_valid_q;
  reg [13:0] ctrl_q;

  reg [15:0] wword;
  reg        wword_vld;

  always @* begin
    wword     = data_prev_q;
    wword_vld = 1'b0;
    if (wr_done) begin
      if (word_md) begin
        wword     = data_prev_q;
        wword_vld = 1'b1;
      end else if (data_prev_q[8]) begin
        // high byte arrives on lines 7:0
        wword     = {data_prev_q[7:0], low_byte_q};
        wword_vld = low_valid_q;
      end
    end
  end

  wire [1:0] waddr   = wword[`ADCRC_ADDR_MSB:`ADCRC_ADDR_LSB];
  wire       ctrl_wr = wword_vld & (waddr == `ADCRC_ADDR_CONTROL);
  wire       sw_start = ctrl_wr & wword[`ADCRC_BIT_START];

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_byte_q  <= 8'h00;
      low_valid_q <= 1'b0;
    end else if (wr_done && !word_md) begin
      if (!data_prev_q[8]) begin
        low_byte_q  <= data_prev_q[7:0];
        low_valid_q <= 1'b1;
      end else begin
        low_valid_q <= 1'b0;
      end
    end
  end

  // conversion sequencer
  reg [1:0] state_q;
  reg [3:0] since_q;
  reg [5:0] half_q;
  reg [11:0] result_q;

  wire conv_done = (state_q == ST_CONV) && mclk_edge && (half_q == CONV_HALF - 6'h01);
  wire start_req = (hw_start | sw_start) && (state_q == ST_IDLE);

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      since_q <= 4'h0;
      half_q  <= 6'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          since_q <= 4'h0;
          half_q  <= 6'h00;
          if (start_req) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (since_q != 4'hf) begin
            since_q <= since_q + 4'h1;
          end
          // a falling edge too close to the start is skipped, adding a period
          if (mclk_fall && (since_q >= SETUP_CYC - 4'h1)) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (mclk_edge) begin
            half_q <= half_q + 6'h01;
          end
          if (conv_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // control register, write-only
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q <= `ADCRC_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= wword[13:0] & `ADCRC_CTRL_KEEP_MASK;
      end
      // a fresh start request in the same cycle wins over the clear
      if (conv_done && !sw_start) begin
        ctrl_q[`ADCRC_BIT_START] <= 1'b0;
      end
    end
  end

  wire       in_mode = ctrl_q[`ADCRC_BIT_INMODE];
  wire       analog_mode_bit   = ctrl_q[`ADCRC_BIT_ANALOG_MODE_BIT];
  wire [2:0] chsel   = ctrl_q[`ADCRC_CHSEL_MSB:`ADCRC_CHSEL_LSB];
  wire [1:0] pmgt    = ctrl_q[`ADCRC_PMGT_MSB:`ADCRC_PMGT_LSB];
  wire [1:0] rdsel   = ctrl_q[`ADCRC_RDSEL_MSB:`ADCRC_RDSEL_LSB];
  wire       bip     = ~in_mode & analog_mode_bit;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_q <= 12'h000;
    end else if (conv_done) begin
      result_q <= adcrc_code(conv_code_in, bip);
    end
  end

  // status word; zero-filled while busy is low at power-up
  wire [15:0] status_w = {2'h0, in_mode, chsel, pmgt, 2'h0, analog_mode_bit, busy_out, 4'h0};

  // front-end decode
  reg [2:0] pos_d;
  reg [1:0] neg_d;
  reg       unused_d;
  reg [1:0] pwr_d;
  reg       pdn_d;
  reg       busy_d;

  always @* begin
    if (in_mode) begin
      pos_d    = {chsel[1:0], chsel[2]};
      neg_d    = analog_mode_bit ? `ADCRC_NEG_INPUT8 : `ADCRC_NEG_GROUND;
      unused_d = 1'b0;
    end else begin
      pos_d    = {chsel[1:0], 1'b0};
      neg_d    = `ADCRC_NEG_PAIR;
      unused_d = chsel[2];
    end
    case (pmgt)
      2'h1:    pwr_d = `ADCRC_PWR_DOWN_BETW;
      2'h2:    pwr_d = `ADCRC_PWR_FULL_DOWN;
      2'h3:    pwr_d = `ADCRC_PWR_PART_BETW;
      default: pwr_d = sleep_n ? `ADCRC_PWR_FULL_UP : `ADCRC_PWR_DOWN_BETW;
    endcase
    busy_d = (state_q != ST_IDLE) | start_req;
    case (pwr_d)
      `ADCRC_PWR_FULL_DOWN: pdn_d = 1'b1;
      `ADCRC_PWR_FULL_UP:   pdn_d = 1'b0;
      default:              pdn_d = ~busy_d;
    endcase
  end

  wire [15:0] rd_word = adcrc_read_word(rdsel, result_q, status_w);

  // registered outputs
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_out            <= 1'b0;
      hold_out            <= 1'b0;
      pos_input_out       <= 3'h0;
      neg_input_out       <= 2'h0;
      channel_unused_out  <= 1'b0;
      bipolar_out         <= 1'b0;
      power_mode_out      <= 2'h0;
      power_down_out      <= 1'b0;
      data_lines_out      <= 16'h0000;
      data_lines_oe_n_out <= 1'b1;
    end else begin
      busy_out            <= busy_d & ~conv_done;
      hold_out            <= busy_d & ~conv_done;
      pos_input_out       <= pos_d;
      neg_input_out       <= neg_d;
      channel_unused_out  <= unused_d;
      bipolar_out         <= bip;
      power_mode_out      <= pwr_d;
      power_down_out      <= pdn_d;
      data_lines_oe_n_out <= cs_n | rd_n;
      if (!word_md && data_s[8]) begin
        data_lines_out <= {8'h00, rd_word[15:8]};
      end else begin
        data_lines_out <= rd_word;
      end
    end
  end

endmodule

// ===== adcrc_top_sva.sv
// assertion checker for the converter control block
`timescale 1ns/10ps
`include "adcrc_regs.vh"
module adcrc_top_sva (
  // clock, reset and pins
  input wire       clk_in,
  input wire       reset_n_in,
  input wire       start_pin_in,
  input wire       chip_select_n_in,
  input wire       read_strobe_n_in,
  // outputs watched
  input wire       data_lines_oe_n_out,
  input wire       busy_out,
  input wire       hold_out,
  input wire [2:0] pos_input_out,
  input wire [1:0] neg_input_out,
  input wire       channel_unused_out,
  input wire       bipolar_out,
  input wire [1:0] power_mode_out,
  input wire       power_down_out
);
  // bounds assume a 125ns master clock: 33 half periods plus start wait and sync slack
  logic [8:0] busy_cnt_q;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      busy_cnt_q <= 9'h0;
    else
      busy_cnt_q <= busy_out ? busy_cnt_q + 9'h1 : 9'h0;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_read_held; (!chip_select_n_in && !read_strobe_n_in) [*5]; endsequence
  sequence s_bus_idle; chip_select_n_in [*5]; endsequence
  a_hold_tracks_busy: assert property (hold_out == busy_out) else $error("hold differs from busy");
  a_start_sets_busy: assert property ($rose(start_pin_in) && !busy_out |-> ##[1:6] busy_out)
    else $error("start pin did not raise busy");
  a_conv_length: assert property ($fell(busy_out) |-> busy_cnt_q >= 9'd195 && busy_cnt_q <= 9'd235)
    else $error("conversion length out of range");
  a_read_drives: assert property (s_read_held |-> !data_lines_oe_n_out) else $error("read not driven");
  a_idle_released: assert property (s_bus_idle |-> data_lines_oe_n_out) else $error("bus driven while idle");
  a_bipolar_pair: assert property (bipolar_out |-> neg_input_out == `ADCRC_NEG_PAIR)
    else $error("bipolar outside differential mode");
  a_pair_even: assert property (neg_input_out == `ADCRC_NEG_PAIR && !channel_unused_out |-> !pos_input_out[0])
    else $error("pair starts on odd input");
  a_single_plain: assert property (neg_input_out != `ADCRC_NEG_PAIR |-> !bipolar_out && !channel_unused_out)
    else $error("single-ended flags wrong");
  a_pdown_full: assert property (power_mode_out == `ADCRC_PWR_FULL_DOWN [*2] |-> power_down_out)
    else $error("full power-down not applied");
  a_pdown_none: assert property (power_mode_out == `ADCRC_PWR_FULL_UP [*2] |-> !power_down_out)
    else $error("power-down in full power-up");
  a_pdown_betw: assert property ((power_mode_out == `ADCRC_PWR_DOWN_BETW && busy_out) [*2] |-> !power_down_out)
    else $error("powered down during conversion");
endmodule
bind adcrc_top adcrc_top_sva u_sva (.clk_in(clk_in), .reset_n_in(reset_n_in), .start_pin_in(start_pin_in),
  .chip_select_n_in(chip_select_n_in), .read_strobe_n_in(read_strobe_n_in),
  .data_lines_oe_n_out(data_lines_oe_n_out), .busy_out(busy_out), .hold_out(hold_out),
  .pos_input_out(pos_input_out), .neg_input_out(neg_input_out), .channel_unused_out(channel_unused_out),
  .bipolar_out(bipolar_out), .power_mode_out(power_mode_out), .power_down_out(power_down_out));

// ===== adcrc_host.sv
// processor model on the parallel register port
`timescale 1ns/10ps
module adcrc_host (
  // clock
  input  wire        clk_in,
  // bus toward the device
  input  wire [15:0] data_lines_out,
  input  wire        data_lines_oe_n_out,
  output reg         chip_select_n_out = 1'b1,
  output reg         write_strobe_n_out = 1'b1,
  output reg         read_strobe_n_out = 1'b1,
  output reg         width_select_pin_out = 1'b1,
  output reg  [15:0] data_out = 16'h0
);
  task automatic strobe(input logic [15:0] d);
    @(negedge clk_in);
    chip_select_n_out = 1'b0;
    data_out = d;
    write_strobe_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    write_strobe_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
    chip_select_n_out = 1'b1;
    // released lines never repeat the old value
    data_out = ~d;
  endtask
  // word mode when high, byte mode when low; changed only between transfers
  task automatic mode(input bit word);
    @(negedge clk_in);
    width_select_pin_out = word;
  endtask
  task automatic wr(input logic [15:0] w);
    if (width_select_pin_out)
      strobe(w);
    else begin
      strobe({8'h00, w[7:0]});
      strobe({7'h00, 1'b1, w[15:8]});
    end
  endtask
  task automatic rd(output logic [15:0] d, output bit ok);
    int n;
    @(negedge clk_in);
    chip_select_n_out = 1'b0;
    read_strobe_n_out = 1'b0;
    n = 0;
    while (data_lines_oe_n_out !== 1'b0 && n < 10) begin
      @(negedge clk_in);
      n++;
    end
    ok = (n < 10);
    repeat (2) @(negedge clk_in);
    d = data_lines_out;
    read_strobe_n_out = 1'b1;
    chip_select_n_out = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask
endmodule

// ===== tb_adc_conversion_register_control.sv
// testbench for the converter control block
`timescale 1ns/10ps
`include "adcrc_regs.vh"
module tb_adc_conversion_register_control;
  logic        clk_in = 1'b0;
  logic        reset_n_in;
  logic        start_pin_in;
  logic        master_clock_in = 1'b0;
  logic        sleep_pin_n_in;
  logic [11:0] conv_code_in;
  wire         cs_n, wr_n, rd_n, wsel, oe_n, busy, hold, unused, bip, pdown;
  wire  [15:0] host_data, dev_data;
  wire  [2:0]  pos;
  wire  [1:0]  neg, pmode;
  wire  [15:0] bus = oe_n ? host_data : dev_data;
  int          failures = 0;
  int          checks_done = 0;
  logic [15:0] rdata;
  logic [3:0]  m;
  bit          ok;

  adcrc_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .start_pin_in(start_pin_in),
    .master_clock_in(master_clock_in), .sleep_pin_n_in(sleep_pin_n_in), .chip_select_n_in(cs_n),
    .write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n), .width_select_pin_in(wsel), .data_lines_in(bus),
    .data_lines_out(dev_data), .data_lines_oe_n_out(oe_n), .conv_code_in(conv_code_in), .busy_out(busy),
    .hold_out(hold), .pos_input_out(pos), .neg_input_out(neg), .channel_unused_out(unused),
    .bipolar_out(bip), .power_mode_out(pmode), .power_down_out(pdown));
  adcrc_host host (.clk_in(clk_in), .data_lines_out(dev_data), .data_lines_oe_n_out(oe_n),
    .chip_select_n_out(cs_n), .write_strobe_n_out(wr_n), .read_strobe_n_out(rd_n),
    .width_select_pin_out(wsel), .data_out(host_data));

  initial forever #5 clk_in = ~clk_in;
  // free-running 8MHz master clock, unrelated in phase
  initial forever #62.5 master_clock_in = ~master_clock_in;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd_chk(input logic [15:0] exp);
    host.rd(rdata, ok);
    chk({15'h0, ok}, 16'h1);
    chk(rdata, exp);
  endtask
  task automatic conv_wait;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    chk({15'h0, busy}, 16'h1);
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    chk({15'h0, busy}, 16'h0);
  endtask
  task automatic pulse;
    repeat (25) @(negedge clk_in);
    start_pin_in = 1'b1;
    repeat (3) @(negedge clk_in);
    start_pin_in = 1'b0;
  endtask

  initial begin
    #200000;
    failures++;
    stop_test;
  end

  initial begin
    reset_n_in = 1'b0;
    start_pin_in = 1'b0;
    sleep_pin_n_in = 1'b1;
    conv_code_in = 12'h9a5;
    repeat (16) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk({14'h0, pmode}, {14'h0, `ADCRC_PWR_FULL_UP});
    sleep_pin_n_in = 1'b0;
    repeat (5) @(negedge clk_in);
    chk({14'h0, pmode}, {14'h0, `ADCRC_PWR_DOWN_BETW});
    rd_chk(16'h0000);
    host.wr(16'hc0c0);
    rd_chk(`ADCRC_STATUS_RESET);
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      host.wr({2'b11, m, 2'b10, 2'b11, 6'h00});
      chk({13'h0, unused, neg}, {13'h0, !m[3] & m[2], m[3] ? `ADCRC_NEG_GROUND : `ADCRC_NEG_PAIR});
      if (m[3] || !m[2])
        chk({13'h0, pos}, {13'h0, m[1:0], m[3] & m[2]});
      chk({14'h0, pmode}, {14'h0, `ADCRC_PWR_FULL_DOWN});
      rd_chk({2'b00, m, 2'b10, 8'h00});
    end
    host.wr(16'h3ff0);
    host.wr(16'h7ff0);
    rd_chk(16'h3e00);
    host.mode(1'b0);
    host.wr(16'he0ef);
    host.mode(1'b1);
    chk({10'h0, bip, neg, pos}, {10'h0, 1'b0, `ADCRC_NEG_INPUT8, 3'h0});
    rd_chk(16'h2020);
    host.wr(16'hc010);
    conv_wait;
    rd_chk(16'h09a5);
    host.wr(16'hc0d0);
    rd_chk(16'h0010);
    conv_wait;
    rd_chk(16'h0000);
    host.wr(16'hc030);
    conv_wait;
    rd_chk(16'h01a5);
    conv_code_in = 12'h5c3;
    pulse;
    repeat (30) @(negedge clk_in);
    pulse;
    conv_wait;
    repeat (30) @(negedge clk_in);
    chk({15'h0, busy}, 16'h0);
    rd_chk(16'h0dc3);
    stop_test;
  end
endmodule
